//--- rtl/nct_pkg.sv
// nct_pkg: constants, types and length/cycle tables of the nibble core.
// assumes: every user names items as nct_pkg::name, nothing is imported.
package nct_pkg;
	localparam int PC_W = 14;
	// avalon register map, byte addresses
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_BANKS = 5'h08;
	localparam logic [4:0] OFS_REGS = 5'h0c;
	localparam logic [4:0] OFS_CYCLES = 5'h10;
	localparam logic [4:0] OFS_PC = 5'h14;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_SEL_LO = 1;
	localparam int CTRL_WAKE = 3;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int ST_FLAGS_LO = 16;
	localparam int ST_SKIP = 22;
	localparam int BK_RB_LO = 4;
	localparam int BK_SP_LO = 8;
	// register file slots; pair n is slot 2n+1 (high) : slot 2n (low)
	localparam logic [2:0] R_A = 3'h0;
	localparam logic [2:0] R_E = 3'h1;
	localparam logic [2:0] R_L = 3'h2;
	localparam logic [2:0] R_H = 3'h3;
	localparam logic [2:0] R_X = 3'h4;
	localparam logic [2:0] R_W = 3'h5;
	// opcode groups, high nibble of the first byte
	localparam logic [3:0] GRP_MISC1 = 4'h0;
	localparam logic [3:0] GRP_JRIM = 4'h1;
	localparam logic [3:0] GRP_LDIM = 4'h2;
	localparam logic [3:0] GRP_STK = 4'h3;
	localparam logic [3:0] GRP_MISC2 = 4'h4;
	localparam logic [3:0] GRP_CPRI = 4'h5;
	localparam logic [3:0] GRP_LDRR = 4'h6;
	localparam logic [3:0] GRP_SHORT_INVOKE = 4'h7;
	localparam logic [3:0] GRP_JPS = 4'h8;
	localparam logic [3:0] GRP_JP = 4'hc;
	localparam logic [3:0] GRP_CALL = 4'hd;
	// one-byte group, low nibble
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_SCF = 4'h1;
	localparam logic [3:0] OP_RCF = 4'h2;
	localparam logic [3:0] OP_CCF = 4'h3;
	localparam logic [3:0] OP_RRC = 4'h4;
	localparam logic [3:0] OP_CPAM = 4'h5;
	localparam logic [3:0] OP_XCH = 4'h6;
	localparam logic [3:0] OP_SWAP_STEP_UP = 4'h7;
	localparam logic [3:0] OP_SWAP_STEP_DOWN = 4'h8;
	localparam logic [3:0] OP_LDI = 4'h9;
	localparam logic [3:0] OP_LDD = 4'ha;
	localparam logic [3:0] OP_LDCWX = 4'hb;
	localparam logic [3:0] OP_LDCEA = 4'hc;
	localparam logic [3:0] OP_RET = 4'hd;
	localparam logic [3:0] OP_INTERRUPT_EXIT = 4'he;
	localparam logic [3:0] OP_SUBROUTINE_EXIT_SKIP = 4'hf;
	// two-byte group, low nibble
	localparam logic [3:0] OP_EI = 4'h0;
	localparam logic [3:0] OP_DI = 4'h1;
	localparam logic [3:0] OP_IDLE = 4'h2;
	localparam logic [3:0] OP_STOP = 4'h3;
	localparam logic [3:0] OP_SMB = 4'h4;
	localparam logic [3:0] OP_SRB = 4'h5;
	localparam logic [3:0] OP_VENT = 4'h6;
	localparam logic [3:0] OP_CPER = 4'h7;
	localparam logic [3:0] OP_JRWX = 4'h8;
	localparam logic [3:0] OP_JREA = 4'h9;
	localparam logic [3:0] OP_PUSHSB = 4'ha;
	localparam logic [3:0] OP_POPSB = 4'hb;

	typedef enum logic [1:0] {
		SQ_HALT = 2'h0,
		SQ_EXEC = 2'h1,
		SQ_SKIP = 2'h3,
		SQ_SKIP2 = 2'h2
	} nct_seq_t;

	typedef struct packed {
		logic mem_bank_enable_flag;
		logic reg_bank_enable_flag;
		logic irq_en;
		logic idle;
		logic stop;
		logic carry;
	} nct_flags_t;

	localparam nct_flags_t FLAGS_RST = 6'h00;

	function automatic logic [1:0] insn_len(input logic [7:0] op);
		case (op[7:4])
		GRP_MISC2, GRP_CPRI, GRP_LDRR, GRP_SHORT_INVOKE, GRP_JPS: insn_len = 2'h2;
		GRP_JP, GRP_CALL: insn_len = 2'h3;
		default: insn_len = 2'h1;
		endcase
	endfunction

	function automatic logic [2:0] insn_cyc(input logic [7:0] op);
		case (op[7:4])
		GRP_MISC1:
			if (op[3:0] >= OP_LDCWX)
				insn_cyc = 3'h3;
			else if (op[3:0] >= OP_SWAP_STEP_UP)
				insn_cyc = 3'h2;
			else
				insn_cyc = 3'h1;
		GRP_MISC2:
			if (op[3:0] == OP_JRWX || op[3:0] == OP_JREA)
				insn_cyc = 3'h3;
			else
				insn_cyc = 3'h2;
		GRP_JRIM, GRP_CPRI, GRP_LDRR, GRP_JPS: insn_cyc = 3'h2;
		GRP_SHORT_INVOKE, GRP_JP: insn_cyc = 3'h3;
		GRP_CALL: insn_cyc = 3'h4;
		default: insn_cyc = 3'h1;
		endcase
	endfunction
endpackage

//--- rtl/nct_mcyc_div.sv
// nct_mcyc_div: machine-cycle enable, one sys_clk pulse per cpu clock.
// assumes: sel is steady while en is high; changes apply at next reload.
`timescale 1ns/100ps
module nct_mcyc_div #(
	parameter int DIV_FAST = 1,
	parameter int DIV_MID = 2,
	parameter int DIV_SLOW = 16,
	parameter int CNT_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [1:0] sel,
	output logic tick
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	wire logic [CNT_W-1:0] reload = (sel == 2'h0) ? CNT_W'(DIV_FAST - 1) :
		(sel == 2'h1) ? CNT_W'(DIV_MID - 1) : CNT_W'(DIV_SLOW - 1);

	// first pulse comes in the cycle en rises
	assign tick = en & (cnt_q == '0);

	always_comb
	begin
		if (!en)
			cnt_d = '0;
		else if (tick)
			cnt_d = reload;
		else
			cnt_d = cnt_q - CNT_W'(1);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule

//--- rtl/nct_core.sv
// nct_core: decode and machine-cycle sequencing of the nibble core.
// assumes: program memory answers pm_addr combinationally on sys_clk,
// settled by the next machine-cycle pulse; avalon master on sys_clk.
`timescale 1ns/100ps
// Overview of operation
// - carry set/clear/invert and nop: 1 byte, 1 cycle
// - irq on/off, idle, stop, bank selects: 2/2
// - vector entry loads bank flags and pc: 2/2
// - register vs immediate compare-skip: 2 bytes, 2+S
// - accumulator vs indirect memory compare-skip: 1, 1+S
// - wide accumulator vs pair compare-skip: 2, 2+S
// - long jump, 14-bit target: 3 bytes, 3 cycles
// - in-page jump, 12-bit target: 2 bytes, 2 cycles
// - pair-relative branch 2/3, short relative 1/2
// - long call, 14-bit target: 3 bytes, 4 cycles
// - short call, 11-bit target: 2 bytes, 3 cycles
// - returns one byte, 3 cycles; skip variant 3+S
// - accumulator/indirect memory swap: 1 byte, 1 cycle
// - swap, pointer low up, skip on carry: 2+S
// - swap, pointer low down, skip on borrow: 2+S
// - load immediate nibble to accumulator: 1/1
// - load immediate byte to pair: 2/2
// - load, pointer low up, skip on carry: 2+S
// - load, pointer low down, skip on borrow: 2+S
// - code byte fetch to wide accumulator: 1/3
// - rotate accumulator right through carry: 1/1
// - pair push/pop 1/1, bank pair push/pop 2/2
// - skip costs 1 cycle, or 2 for 3-byte
// - machine cycle is one selected cpu clock period
module nct_core #(
	parameter int DM_AW = 8,
	parameter int SP_W = 3,
	parameter int DIV_FAST = 1,
	parameter int DIV_MID = 2,
	parameter int DIV_SLOW = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [13:0] pm_addr,
	input wire logic [7:0] pm_rdata
);
	localparam int PW = nct_pkg::PC_W;

	nct_pkg::nct_seq_t st_q, st_d;
	nct_pkg::nct_flags_t fl_q, fl_d;
	logic [PW-1:0] pc_q, pc_d;
	logic [1:0] cyc_q, cyc_d;
	logic [7:0] ir0_q, ir1_q, ir2_q;
	logic [7:0][3:0] rf_q, rf_d;
	logic [3:0] mb_q, mb_d, rb_q, rb_d;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [2:0] ctrl_q;
	logic [31:0] ncyc_q;
	logic ack_q;
	logic [31:0] rd_q;
	logic [3:0] dmem [2**DM_AW];
	logic [PW-1:0] stk [2**SP_W];
	logic dm_we, stk_we, skip_take;
	logic [3:0] dm_wd;
	logic [PW-1:0] stk_wd;

	function automatic logic [PW-1:0] rel_tgt(input logic [PW-1:0] p,
		input logic [7:0] o);
		rel_tgt = p + {{(PW-8){o[7]}}, o};
	endfunction

	// machine-cycle pulse at the selected rate
	wire logic tick;
	nct_mcyc_div #(
		.DIV_FAST(DIV_FAST),
		.DIV_MID(DIV_MID),
		.DIV_SLOW(DIV_SLOW),
		.CNT_W(8)
	) u_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(ctrl_q[nct_pkg::CTRL_RUN]),
		.sel(ctrl_q[nct_pkg::CTRL_SEL_LO +: 2]),
		.tick(tick)
	);

	// bus decode
	wire logic req = avs_read | avs_write;
	wire logic wr_now = avs_write & ack_q;
	wire logic wr_ctrl = wr_now & (avs_address == nct_pkg::OFS_CTRL);
	wire logic wake = wr_ctrl & avs_writedata[nct_pkg::CTRL_WAKE];
	wire logic pc_ld = wr_now & (avs_address == nct_pkg::OFS_PC)
		& (st_q == nct_pkg::SQ_HALT);
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rd_q;

	// instruction bytes: the byte of this cycle comes straight off the bus
	wire logic [7:0] b0 = (cyc_q == 2'h0) ? pm_rdata : ir0_q;
	wire logic [7:0] b1 = (cyc_q == 2'h1) ? pm_rdata : ir1_q;
	wire logic [7:0] b2 = (cyc_q == 2'h2) ? pm_rdata : ir2_q;
	wire logic [3:0] grp = b0[7:4];
	wire logic [3:0] sub = b0[3:0];
	wire logic [1:0] len0 = nct_pkg::insn_len(b0);
	wire logic [2:0] ncy0 = nct_pkg::insn_cyc(b0);
	wire logic fetch_b = cyc_q < len0;
	wire logic last = {1'b0, cyc_q} == (ncy0 - 3'h1);
	wire logic [1:0] skl = nct_pkg::insn_len(pm_rdata);

	// operands
	wire logic [3:0] acc = rf_q[nct_pkg::R_A];
	wire logic [3:0] lo_l = rf_q[nct_pkg::R_L];
	wire logic [DM_AW-1:0] hl =
		DM_AW'({rf_q[nct_pkg::R_H], rf_q[nct_pkg::R_L]});
	wire logic [3:0] mem = dmem[hl];
	wire logic [7:0] wx = {rf_q[nct_pkg::R_W], rf_q[nct_pkg::R_X]};
	wire logic [7:0] ea = {rf_q[nct_pkg::R_E], rf_q[nct_pkg::R_A]};
	wire logic [7:0] pr_a = {rf_q[{b0[2:1], 1'b1}], rf_q[{b0[2:1], 1'b0}]};
	wire logic [7:0] pr_b = {rf_q[{b1[2:1], 1'b1}], rf_q[{b1[2:1], 1'b0}]};
	wire logic [PW-1:0] stk_top = stk[sp_q - SP_W'(1)];
	wire logic step_up = (sub == nct_pkg::OP_SWAP_STEP_UP) | (sub == nct_pkg::OP_LDI);
	wire logic step_xc = (sub == nct_pkg::OP_SWAP_STEP_UP) | (sub == nct_pkg::OP_SWAP_STEP_DOWN);
	wire logic go = ctrl_q[nct_pkg::CTRL_RUN] & ~fl_q.idle & ~fl_q.stop;

	// code byte fetch points program memory at a pair during cycle 1
	wire logic ldc_now = (st_q == nct_pkg::SQ_EXEC) & (cyc_q == 2'h1)
		& (ir0_q[7:4] == nct_pkg::GRP_MISC1)
		& (ir0_q[3:0] == nct_pkg::OP_LDCWX | ir0_q[3:0] == nct_pkg::OP_LDCEA);
	wire logic [7:0] ldc_src = (ir0_q[3:0] == nct_pkg::OP_LDCWX) ? wx : ea;
	assign pm_addr = ldc_now ? {pc_q[PW-1:8], ldc_src} : pc_q;

	always_comb
	begin
		st_d = st_q;
		cyc_d = cyc_q;
		pc_d = pc_q;
		fl_d = fl_q;
		rf_d = rf_q;
		mb_d = mb_q;
		rb_d = rb_q;
		sp_d = sp_q;
		dm_we = 1'b0;
		dm_wd = acc;
		stk_we = 1'b0;
		stk_wd = pc_q;
		skip_take = 1'b0;
		// wake first so an idle or stop executed this cycle still sticks
		if (wake)
		begin
			fl_d.idle = 1'b0;
			fl_d.stop = 1'b0;
		end
		if (pc_ld)
			pc_d = avs_writedata[PW-1:0];
		case (st_q)
		nct_pkg::SQ_HALT:
			if (go)
				st_d = nct_pkg::SQ_EXEC;
		nct_pkg::SQ_EXEC:
			if (tick)
			begin
				if (fetch_b)
					pc_d = pc_q + PW'(1);
				cyc_d = cyc_q + 2'h1;
				if (last)
				begin
					cyc_d = 2'h0;
					case (grp)
					nct_pkg::GRP_MISC1:
						case (sub)
						nct_pkg::OP_SCF: fl_d.carry = 1'b1;
						nct_pkg::OP_RCF: fl_d.carry = 1'b0;
						nct_pkg::OP_CCF: fl_d.carry = ~fl_q.carry;
						nct_pkg::OP_RRC:
						begin
							rf_d[nct_pkg::R_A] = {fl_q.carry, acc[3:1]};
							fl_d.carry = acc[0];
						end
						nct_pkg::OP_CPAM: skip_take = (acc == mem);
						nct_pkg::OP_XCH:
						begin
							rf_d[nct_pkg::R_A] = mem;
							dm_we = 1'b1;
						end
						nct_pkg::OP_SWAP_STEP_UP, nct_pkg::OP_SWAP_STEP_DOWN,
						nct_pkg::OP_LDI, nct_pkg::OP_LDD:
						begin
							rf_d[nct_pkg::R_A] = mem;
							dm_we = step_xc;
							rf_d[nct_pkg::R_L] = step_up ? lo_l + 4'h1 : lo_l - 4'h1;
							// up skips on carry out, down on borrow
							skip_take = step_up ? (lo_l == 4'hf) : (lo_l == 4'h0);
						end
						nct_pkg::OP_LDCWX, nct_pkg::OP_LDCEA:
						begin
							rf_d[nct_pkg::R_A] = ir1_q[3:0];
							rf_d[nct_pkg::R_E] = ir1_q[7:4];
						end
						nct_pkg::OP_RET, nct_pkg::OP_INTERRUPT_EXIT, nct_pkg::OP_SUBROUTINE_EXIT_SKIP:
						begin
							pc_d = stk_top;
							sp_d = sp_q - SP_W'(1);
							skip_take = (sub == nct_pkg::OP_SUBROUTINE_EXIT_SKIP);
						end
						default:
						begin
						end
						endcase
					nct_pkg::GRP_JRIM:
						pc_d = rel_tgt(pc_q, {{4{sub[3]}}, sub});
					nct_pkg::GRP_LDIM:
						rf_d[nct_pkg::R_A] = sub;
					nct_pkg::GRP_STK:
						if (sub[3])
						begin
							{rf_d[{sub[2:1], 1'b1}], rf_d[{sub[2:1], 1'b0}]} =
								stk_top[7:0];
							sp_d = sp_q - SP_W'(1);
						end
						else
						begin
							stk_we = 1'b1;
							stk_wd = PW'(pr_a);
							sp_d = sp_q + SP_W'(1);
						end
					nct_pkg::GRP_MISC2:
						case (sub)
						nct_pkg::OP_EI: fl_d.irq_en = 1'b1;
						nct_pkg::OP_DI: fl_d.irq_en = 1'b0;
						nct_pkg::OP_IDLE: fl_d.idle = 1'b1;
						nct_pkg::OP_STOP: fl_d.stop = 1'b1;
						nct_pkg::OP_SMB: mb_d = b1[3:0];
						nct_pkg::OP_SRB: rb_d = b1[3:0];
						nct_pkg::OP_VENT:
						begin
							fl_d.mem_bank_enable_flag = b1[7];
							fl_d.reg_bank_enable_flag = b1[6];
							pc_d = PW'(b1[5:0]);
						end
						nct_pkg::OP_CPER: skip_take = (pr_b == ea);
						nct_pkg::OP_JRWX: pc_d = rel_tgt(pc_q, wx);
						nct_pkg::OP_JREA: pc_d = rel_tgt(pc_q, ea);
						nct_pkg::OP_PUSHSB:
						begin
							stk_we = 1'b1;
							stk_wd = PW'({mb_q, rb_q});
							sp_d = sp_q + SP_W'(1);
						end
						nct_pkg::OP_POPSB:
						begin
							{mb_d, rb_d} = stk_top[7:0];
							sp_d = sp_q - SP_W'(1);
						end
						default:
						begin
						end
						endcase
					nct_pkg::GRP_CPRI:
						skip_take = (rf_q[sub[2:0]] == b1[3:0]);
					nct_pkg::GRP_LDRR:
						{rf_d[{sub[2:1], 1'b1}], rf_d[{sub[2:1], 1'b0}]} = b1;
					nct_pkg::GRP_SHORT_INVOKE:
					begin
						stk_we = 1'b1;
						sp_d = sp_q + SP_W'(1);
						pc_d = {pc_q[PW-1:11], sub[2:0], b1};
					end
					nct_pkg::GRP_JPS:
						pc_d = {pc_q[PW-1:12], sub, b1};
					nct_pkg::GRP_JP:
						pc_d = {b1[5:0], b2};
					nct_pkg::GRP_CALL:
					begin
						stk_we = 1'b1;
						sp_d = sp_q + SP_W'(1);
						pc_d = {b1[5:0], b2};
					end
					default:
					begin
					end
					endcase
					if (skip_take)
						st_d = nct_pkg::SQ_SKIP;
					else if (!ctrl_q[nct_pkg::CTRL_RUN] || fl_d.idle || fl_d.stop)
						st_d = nct_pkg::SQ_HALT;
				end
			end
		nct_pkg::SQ_SKIP:
			if (tick)
			begin
				// only the length is looked at; nothing else of it is acted on
				pc_d = pc_q + PW'(skl);
				if (skl == 2'h3)
					st_d = nct_pkg::SQ_SKIP2;
				else
					st_d = go ? nct_pkg::SQ_EXEC : nct_pkg::SQ_HALT;
			end
		nct_pkg::SQ_SKIP2:
			if (tick)
				st_d = go ? nct_pkg::SQ_EXEC : nct_pkg::SQ_HALT;
		default:
			st_d = nct_pkg::SQ_HALT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= nct_pkg::SQ_HALT;
			fl_q <= nct_pkg::FLAGS_RST;
			pc_q <= '0;
			cyc_q <= 2'h0;
			rf_q <= '0;
			mb_q <= 4'h0;
			rb_q <= 4'h0;
			sp_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			fl_q <= fl_d;
			pc_q <= pc_d;
			cyc_q <= cyc_d;
			rf_q <= rf_d;
			mb_q <= mb_d;
			rb_q <= rb_d;
			sp_q <= sp_d;
		end
	end

	// instruction byte latches; cycle 1 of a code fetch grabs the code byte
	wire logic ir_cap = tick & (st_q == nct_pkg::SQ_EXEC);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ir0_q <= 8'h00;
			ir1_q <= 8'h00;
			ir2_q <= 8'h00;
		end
		else if (ir_cap)
		begin
			if (cyc_q == 2'h0)
				ir0_q <= pm_rdata;
			if (cyc_q == 2'h1)
				ir1_q <= pm_rdata;
			if (cyc_q == 2'h2)
				ir2_q <= pm_rdata;
		end
	end

	// memories carry no reset, software must not rely on their contents
	always_ff @(posedge sys_clk)
	begin
		if (dm_we)
			dmem[hl] <= dm_wd;
		if (stk_we)
			stk[sp_q] <= stk_wd;
	end

	// machine cycles spent outside halt, a timing observation point
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ncyc_q <= 32'h0000_0000;
		else if (tick && st_q != nct_pkg::SQ_HALT)
			ncyc_q <= ncyc_q + 32'h0000_0001;
	end

	// avalon slave: one wait state on every access
	wire logic [31:0] st_word = {9'h000, st_q != nct_pkg::SQ_EXEC &&
		st_q != nct_pkg::SQ_HALT, fl_q, 2'h0, pc_q};
	wire logic [31:0] bk_word = {20'h0_0000, 4'(sp_q), rb_q, mb_q};
	wire logic [31:0] rd_mux =
		(avs_address == nct_pkg::OFS_CTRL) ? {29'h0000_0000, ctrl_q} :
		(avs_address == nct_pkg::OFS_STATUS) ? st_word :
		(avs_address == nct_pkg::OFS_BANKS) ? bk_word :
		(avs_address == nct_pkg::OFS_REGS) ? rf_q :
		(avs_address == nct_pkg::OFS_CYCLES) ? ncyc_q :
		(avs_address == nct_pkg::OFS_PC) ? {18'h0_0000, pc_q} :
		32'h0000_0000;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			ctrl_q <= nct_pkg::CTRL_RST;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q)
				rd_q <= rd_mux;
			if (wr_ctrl)
				ctrl_q <= avs_writedata[2:0];
		end
	end
endmodule

//--- sim/nct_core_properties.sv
// nct_core_chk: bus timing and register-view properties of the core.
// assumes: bound into nct_core, one sys_clk domain, rst_n async low.
`timescale 1ns/100ps
module nct_core_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [13:0] pm_addr,
	input wire logic [7:0] pm_rdata
);
	logic [31:0] cyc_q;
	wire logic req = avs_read || avs_write;
	wire logic rd_ok = avs_read && !avs_waitrequest;
	wire logic rd_cyc = rd_ok && avs_address == nct_pkg::OFS_CYCLES;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// last cycle count seen by software, so a count that runs back shows
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			cyc_q <= '0;
		else if (rd_cyc)
			cyc_q <= avs_readdata;
	property p_wait_first;
		$rose(req) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_wait_one;
		$rose(req) |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_wait_idle;
		!req |-> !avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
	property p_rd_hold;
		!req |=> $stable(avs_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		rd_ok && avs_address >= 5'h18 |-> avs_readdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
	property p_status_pad;
		rd_ok && avs_address == nct_pkg::OFS_STATUS |->
			avs_readdata[31:23] == '0 && avs_readdata[15:14] == '0;
	endproperty
	a_status_pad: assert property (p_status_pad) else $error("status pad");
	property p_cyc_mono;
		rd_cyc |-> avs_readdata >= cyc_q;
	endproperty
	a_cyc_mono: assert property (p_cyc_mono) else $error("count fell");
	property p_pc_w;
		rd_ok && avs_address == nct_pkg::OFS_PC |-> avs_readdata[31:14] == '0;
	endproperty
	a_pc_w: assert property (p_pc_w) else $error("pc too wide");
	c_cyc: cover property (rd_cyc);
	c_wr: cover property (avs_write && !avs_waitrequest);
	c_halt: cover property (rd_ok && avs_readdata[nct_pkg::ST_FLAGS_LO + 1]);
endmodule

bind nct_core nct_core_chk u_chk (
	.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .pm_addr, .pm_rdata
);

//--- sim/nct_pm_model.sv
// nct_pm_model: program memory answering pm_addr combinationally.
// assumes: bench loads bytes by hierarchy while the core is halted.
`timescale 1ns/100ps
module nct_pm_model (
	input wire logic [13:0] pm_addr,
	output logic [7:0] pm_rdata
);
	logic [7:0] mem [0:16383];
	// blank space reads as no-op so a runaway pc stays harmless
	initial
		for (int i = 0; i < 16384; i++)
			mem[i] = 8'h00;
	assign pm_rdata = mem[pm_addr];
endmodule

//--- sim/nct_core_tb.sv
// nct_core_tb: runs short programs and checks cycle counts and results.
// assumes: core halts on idle or stop; fast rate except one rerun.
`timescale 1ns/100ps
module nct_core_tb;
	logic sys_clk;
	logic rst_n;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [13:0] pm_addr;
	logic [7:0] pm_rdata;
	logic [31:0] rv;
	logic [31:0] st;
	int bad_count = 0;
	int checks = 0;
	int tnum = 0;

	nct_core #(.DIV_FAST(1), .DIV_MID(2), .DIV_SLOW(16)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata)
	);
	nct_pm_model pm (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	// one avalon transfer; an idle edge follows so no signal is set twice
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		rv = avs_readdata;
		if (n >= 100)
			bad_count++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic put(input logic [13:0] a, input logic [7:0] b [$]);
		foreach (b[i])
			pm.mem[a + 14'(i)] = b[i];
	endtask

	task automatic tend;
		tnum++;
		$display("test %0d done", tnum);
	endtask

	// wake with run low keeps the core halted, so the pc write is accepted
	task automatic run(input logic [13:0] pc0, input logic [2:0] ctl,
		input logic [31:0] ce, input logic [13:0] pe);
		logic [31:0] c0;
		int n;
		bus(1'b1, nct_pkg::OFS_CTRL, 32'h8);
		bus(1'b1, nct_pkg::OFS_PC, 32'(pc0));
		bus(1'b0, nct_pkg::OFS_CYCLES, 32'h0);
		c0 = rv;
		bus(1'b1, nct_pkg::OFS_CTRL, 32'(ctl));
		n = 0;
		do
		begin
			bus(1'b0, nct_pkg::OFS_STATUS, 32'h0);
			n++;
		end
		// stop or idle, either one ends a program
		while (rv[nct_pkg::ST_FLAGS_LO + 1 +: 2] === 2'b00 && n < 100);
		st = rv;
		bus(1'b0, nct_pkg::OFS_CYCLES, 32'h0);
		chk(rv - c0, ce);
		chk(32'(st[13:0]), 32'(pe));
		tend;
	endtask

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		close_out;
	end

	initial
	begin
		rst_n = 1'b0;
		avs_address = 5'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		// every register clear after reset, unmapped offsets included
		for (int a = 0; a < 32; a += 4)
		begin
			bus(1'b0, 5'(a), 32'h0);
			chk(rv, 32'h0);
		end
		bus(1'b1, nct_pkg::OFS_STATUS, 32'hffff_ffff);
		bus(1'b0, nct_pkg::OFS_STATUS, 32'h0);
		chk(rv, 32'h0);
		tend;
		put(14'h0, '{8'h01, 8'h02, 8'h03, 8'h00, 8'h43, 8'h00});
		run(14'h0, 3'h1, 32'h6, 14'h6);
		chk(32'(st[21:16]), 32'h3);
		run(14'h0, 3'h3, 32'h6, 14'h6);
		put(14'h8, '{8'h21, 8'h01, 8'h04, 8'h43, 8'h00});
		run(14'h8, 3'h1, 32'h5, 14'hd);
		bus(1'b0, nct_pkg::OFS_REGS, 32'h0);
		chk(32'(rv[3:0]), 32'h8);
		put(14'h10, '{8'h40, 8'h00, 8'h41, 8'h00, 8'h40, 8'h00, 8'h44,
			8'h05, 8'h45, 8'h03, 8'h43, 8'h00});
		run(14'h10, 3'h1, 32'hc, 14'h1c);
		chk(32'(st[21:16]), 32'hb);
		bus(1'b0, nct_pkg::OFS_BANKS, 32'h0);
		chk(32'(rv[7:0]), 32'h35);
		put(14'h20, '{8'h25, 8'h50, 8'h05, 8'hc0, 8'h3f, 8'hff, 8'h50,
			8'h06, 8'h21, 8'h50, 8'h01, 8'h62, 8'hab, 8'h43, 8'h00});
		run(14'h20, 3'h1, 32'hd, 14'h2f);
		bus(1'b0, nct_pkg::OFS_REGS, 32'h0);
		chk(32'(rv[15:0]), 32'h1);
		put(14'h80, '{8'hc0, 8'h01, 8'h00});
		put(14'h100, '{8'h82, 8'h00});
		put(14'h200, '{8'h12, 8'h00, 8'h00, 8'h43, 8'h00});
		run(14'h80, 3'h1, 32'h9, 14'h205);
		put(14'h300, '{8'hd0, 8'h04, 8'h00, 8'h75, 8'h00, 8'h76, 8'h00,
			8'hc0, 8'h3f, 8'hff, 8'h43, 8'h00});
		put(14'h400, '{8'h0d});
		put(14'h500, '{8'h0e});
		put(14'h600, '{8'h0f});
		run(14'h300, 3'h1, 32'h17, 14'h30c);
		bus(1'b0, nct_pkg::OFS_BANKS, 32'h0);
		chk(32'(rv[10:8]), 32'h0);
		put(14'hc0, '{8'h23, 8'h62, 8'h00, 8'h06, 8'h62, 8'h0f, 8'h2a,
			8'h06, 8'h27, 8'h07, 8'h21, 8'h0a, 8'h21, 8'h09, 8'hc0,
			8'h3f, 8'hff, 8'h05, 8'h08, 8'h21, 8'h43, 8'h00});
		run(14'hc0, 3'h1, 32'h19, 14'hd6);
		bus(1'b0, nct_pkg::OFS_REGS, 32'h0);
		chk(32'(rv[15:0]), 32'h0f03);
		put(14'h700, '{8'h64, 8'h80, 8'h0b, 8'h47, 8'h00, 8'h21, 8'h30,
			8'h3a, 8'h4a, 8'h00, 8'h4b, 8'h00, 8'h46, 8'hff});
		put(14'h780, '{8'h5c});
		put(14'h3f, '{8'h43, 8'h00});
		run(14'h700, 3'h1, 32'h12, 14'h41);
		chk(32'(st[21:16]), 32'h3b);
		bus(1'b0, nct_pkg::OFS_REGS, 32'h0);
		chk(32'(rv[23:0]), 32'h0080_5c5c);
		bus(1'b0, nct_pkg::OFS_BANKS, 32'h0);
		chk(32'(rv[10:0]), 32'h35);
		// equal compare skip, both pair branches, code fetch via EA, idle
		put(14'h800, '{8'h62, 8'h0f, 8'h27, 8'h05, 8'h21, 8'h64, 8'h10,
			8'h48, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h30, 8'h0c,
			8'h42, 8'h00});
		put(14'h819, '{8'h60, 8'hf0, 8'h49, 8'h00});
		put(14'h830, '{8'h9e});
		run(14'h800, 3'h1, 32'h16, 14'h812);
		chk(32'(st[21:16]), 32'h3d);
		bus(1'b0, nct_pkg::OFS_REGS, 32'h0);
		chk(32'(rv[23:0]), 32'h0010_0f9e);
		close_out;
	end
endmodule
